// ### src/flash_reset_pkg.sv
// Constants and types for the flash hardware reset and power-on controller.
// Functional notes
// R1: Full reset only after reset pin held low at least the minimum pulse.
// R2: Reset completion gives standby, volatile defaults and 3-byte addressing.
// R3: Reset during program or erase aborts that operation at once.
// R4: Serial data output stays high impedance while reset is active.
// R5: Host keeps select high for release-to-select time after reset release.
// R6: Recovery 40 us after decode reset, 35 us after read reset.
// R7: Recovery 310 us when reset interrupted a page program.
// R8: Erase recovery 12 ms sector, 25 ms block, 100 ms full array.
// R9: Recovery 40 ms when reset interrupted a register write.
// R10: Power-up enters standby, not deep power-down, with write latch clear.
// R11: Supply below write-inhibit threshold holds logic in reset.
// R12: Host keeps device deselected during power transitions and settling.
// R13: During recovery select activity is ignored and busy is not shown.
package flash_reset_pkg;
  localparam int CLK_MHZ = 100;
  localparam int MIN_RESTART_LOW_PULSE_US = 10;
  localparam int RESTART_RELEASE_TO_SELECT_US = 10;
  localparam int POWER_ON_RECOVERY_US = 35;
  localparam int RECOVERY_DECODE_US = 40;
  localparam int RECOVERY_READ_US = 35;
  localparam int RECOVERY_PROGRAM_US = 310;
  localparam int RECOVERY_SECTOR_MS = 12;
  localparam int RECOVERY_BLOCK_MS = 25;
  localparam int RECOVERY_CHIP_MS = 100;
  localparam int RECOVERY_REG_WRITE_MS = 40;
  localparam int MIN_RESTART_LOW_PULSE_CYC = MIN_RESTART_LOW_PULSE_US * CLK_MHZ;
  localparam int POWER_ON_RECOVERY_CYC = POWER_ON_RECOVERY_US * CLK_MHZ;
  localparam int RECOVERY_DECODE_CYC = RECOVERY_DECODE_US * CLK_MHZ;
  localparam int RECOVERY_READ_CYC = RECOVERY_READ_US * CLK_MHZ;
  localparam int RECOVERY_PROGRAM_CYC = RECOVERY_PROGRAM_US * CLK_MHZ;
  localparam int RECOVERY_SECTOR_CYC = RECOVERY_SECTOR_MS * 1000 * CLK_MHZ;
  localparam int RECOVERY_BLOCK_CYC = RECOVERY_BLOCK_MS * 1000 * CLK_MHZ;
  localparam int RECOVERY_CHIP_CYC = RECOVERY_CHIP_MS * 1000 * CLK_MHZ;
  localparam int RECOVERY_REG_WRITE_CYC = RECOVERY_REG_WRITE_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 24;

  typedef enum logic [2:0] {
    OP_IDLE,
    OP_DECODE,
    OP_READ,
    OP_PROGRAM,
    OP_SECTOR_ERASE,
    OP_BLOCK_ERASE,
    OP_CHIP_ERASE,
    OP_REG_WRITE
  } op_kind_t;

  typedef enum logic [1:0] {
    ST_POWER_HOLD,
    ST_RESET_LOW,
    ST_RECOVER,
    ST_READY
  } seq_state_t;
endpackage

// ### src/flash_reset_ctrl.sv
// Hardware reset and power-on sequencer for the serial flash core.
`timescale 1ns/1ps
module flash_reset_ctrl #(
  parameter int LOW_PULSE_CYC = flash_reset_pkg::MIN_RESTART_LOW_PULSE_CYC,
  parameter int PWR_REC_CYC = flash_reset_pkg::POWER_ON_RECOVERY_CYC,
  parameter int DECODE_CYC = flash_reset_pkg::RECOVERY_DECODE_CYC,
  parameter int READ_CYC = flash_reset_pkg::RECOVERY_READ_CYC,
  parameter int PROGRAM_CYC = flash_reset_pkg::RECOVERY_PROGRAM_CYC,
  parameter int SECTOR_CYC = flash_reset_pkg::RECOVERY_SECTOR_CYC,
  parameter int BLOCK_CYC = flash_reset_pkg::RECOVERY_BLOCK_CYC,
  parameter int CHIP_CYC = flash_reset_pkg::RECOVERY_CHIP_CYC,
  parameter int REG_WRITE_CYC = flash_reset_pkg::RECOVERY_REG_WRITE_CYC
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_restart_n,
  input wire logic i_supply_ok,
  input wire logic i_cs_n,
  input wire flash_reset_pkg::op_kind_t i_op_kind,
  input wire logic i_so_data,
  input wire logic i_so_oe,
  output logic o_so_data,
  output logic o_so_oe,
  output logic o_core_reset,
  output logic o_op_abort,
  output logic o_ready,
  output logic o_busy,
  output logic o_cs_n_core,
  output logic o_write_enable_latch_clr,
  output logic o_addr_4byte,
  output logic o_deep_power_down
);
  import flash_reset_pkg::*;

  localparam int MAXC = CHIP_CYC;

  initial begin
    if (LOW_PULSE_CYC < 1 || PWR_REC_CYC < 1 || DECODE_CYC < 1 ||
        READ_CYC < 1 || PROGRAM_CYC < 1 || SECTOR_CYC < 1 ||
        BLOCK_CYC < 1 || CHIP_CYC < 1 || REG_WRITE_CYC < 1 ||
        MAXC >= (1 << CNT_W) || SECTOR_CYC > MAXC || BLOCK_CYC > MAXC ||
        REG_WRITE_CYC > MAXC)
      $error("flash_reset_ctrl: count parameters out of range");
  end

  function automatic logic [CNT_W-1:0] rec_len(input op_kind_t k);
    case (k)
      OP_DECODE: rec_len = CNT_W'(DECODE_CYC);
      OP_READ: rec_len = CNT_W'(READ_CYC);
      OP_PROGRAM: rec_len = CNT_W'(PROGRAM_CYC);
      // R8: erase recovery lengths
      OP_SECTOR_ERASE: rec_len = CNT_W'(SECTOR_CYC);
      OP_BLOCK_ERASE: rec_len = CNT_W'(BLOCK_CYC);
      OP_CHIP_ERASE: rec_len = CNT_W'(CHIP_CYC);
      // R9: register write recovery
      OP_REG_WRITE: rec_len = CNT_W'(REG_WRITE_CYC);
      default: rec_len = CNT_W'(READ_CYC);
    endcase
  endfunction

  seq_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [CNT_W-1:0] rec_ff, nxt_rec;
  logic abort_ff, nxt_abort;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_rec = rec_ff;
    nxt_abort = 1'b0;
    case (state_ff)
      ST_POWER_HOLD: begin
        nxt_cnt = '0;
        if (i_supply_ok) begin
          nxt_state = ST_RECOVER;
          nxt_rec = CNT_W'(PWR_REC_CYC);
        end
      end
      ST_RESET_LOW: begin
        if (i_restart_n) begin
          // R1: short pulses skip recovery and return straight to ready
          if (cnt_ff >= CNT_W'(LOW_PULSE_CYC)) begin
            nxt_state = ST_RECOVER;
          end else begin
            nxt_state = ST_READY;
          end
          nxt_cnt = '0;
        end else if (cnt_ff < CNT_W'(LOW_PULSE_CYC)) begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      ST_RECOVER: begin
        // R6: recovery length chosen by op
        if (!i_restart_n) begin
          nxt_state = ST_RESET_LOW;
          nxt_cnt = CNT_W'(1);
        end else if (cnt_ff + 1'b1 >= rec_ff) begin
          nxt_state = ST_READY;
          nxt_cnt = '0;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      ST_READY: begin
        if (!i_restart_n) begin
          nxt_state = ST_RESET_LOW;
          nxt_cnt = CNT_W'(1);
          // R7: latch interrupted op length
          nxt_rec = rec_len(i_op_kind);
          // R3: abort program, erase or register write
          nxt_abort = (i_op_kind == OP_PROGRAM) ||
                      (i_op_kind == OP_SECTOR_ERASE) ||
                      (i_op_kind == OP_BLOCK_ERASE) ||
                      (i_op_kind == OP_CHIP_ERASE) ||
                      (i_op_kind == OP_REG_WRITE);
        end
      end
      default: nxt_state = ST_POWER_HOLD;
    endcase
    // R11: low supply forces reset
    if (!i_supply_ok) begin
      nxt_state = ST_POWER_HOLD;
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_ff <= ST_POWER_HOLD;
      cnt_ff <= '0;
      rec_ff <= '0;
      abort_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      rec_ff <= nxt_rec;
      abort_ff <= nxt_abort;
    end
  end

  logic so_data_ff, nxt_so_data;
  logic so_oe_ff, nxt_so_oe;
  logic in_reset;

  assign in_reset = (state_ff != ST_READY) || !i_restart_n;

  always_comb begin
    // R4: output released in reset
    nxt_so_oe = i_so_oe && !in_reset && i_restart_n;
    nxt_so_data = nxt_so_oe ? i_so_data : 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      so_oe_ff <= 1'b0;
      so_data_ff <= 1'b0;
    end else begin
      so_oe_ff <= nxt_so_oe;
      so_data_ff <= nxt_so_data;
    end
  end

  assign o_so_oe = so_oe_ff && i_restart_n;
  assign o_so_data = so_data_ff;
  // R2: core held at defaults until ready
  assign o_core_reset = in_reset;
  assign o_write_enable_latch_clr = in_reset;
  assign o_addr_4byte = 1'b0;
  // R10: never deep power-down
  assign o_deep_power_down = 1'b0;
  assign o_op_abort = abort_ff;
  assign o_ready = !in_reset;
  // R13: select ignored, busy hidden
  assign o_cs_n_core = in_reset ? 1'b1 : i_cs_n;
  assign o_busy = 1'b0;

  sequence reset_low_s;
    !i_restart_n && state_ff == ST_READY;
  endsequence

  // R3: abort follows the reset edge
  abort_pulse_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R3
    reset_low_s ##0 (i_op_kind == OP_PROGRAM) && i_supply_ok |=> o_op_abort)
    else $error("program not aborted on reset");
  so_hiz_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R4
    !i_restart_n |-> !o_so_oe)
    else $error("data output driven during reset");
  supply_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R11
    !i_supply_ok |=> o_core_reset && state_ff == ST_POWER_HOLD)
    else $error("logic not held with low supply");
  select_mask_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R13
    state_ff == ST_RECOVER |-> o_cs_n_core && !o_busy)
    else $error("select passed during recovery");
  short_pulse_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R1
    state_ff == ST_RESET_LOW && i_restart_n && i_supply_ok &&
    cnt_ff < CNT_W'(LOW_PULSE_CYC) |=> state_ff == ST_READY)
    else $error("short reset pulse acted");
  full_reset_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R1
    state_ff == ST_RESET_LOW && i_restart_n && i_supply_ok &&
    cnt_ff >= CNT_W'(LOW_PULSE_CYC) |=> state_ff == ST_RECOVER)
    else $error("long reset pulse did not start recovery");
  rec_latch_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R7
    reset_low_s ##0 i_supply_ok |=> rec_ff == rec_len($past(i_op_kind)))
    else $error("recovery length not latched");
  defaults_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R2
    o_core_reset |-> o_write_enable_latch_clr && !o_addr_4byte && !o_ready)
    else $error("defaults not held in reset");
  no_dpd_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R10
    $rose(o_ready) |-> !o_deep_power_down)
    else $error("came up in deep power-down");

  // R6: decode recovery length
  rec_decode_a: assert property (@(posedge i_clk) // R6
    disable iff (!i_resetn)
    reset_low_s ##0 i_op_kind == OP_DECODE && i_supply_ok
    |=> rec_ff == CNT_W'(DECODE_CYC))
    else $error("decode recovery length wrong");

  // R6: read recovery length
  rec_read_a: assert property (@(posedge i_clk) // R6
    disable iff (!i_resetn)
    reset_low_s ##0 i_op_kind == OP_READ && i_supply_ok
    |=> rec_ff == CNT_W'(READ_CYC))
    else $error("read recovery length wrong");

  // R7: program recovery length
  rec_prog_a: assert property (@(posedge i_clk) // R7
    disable iff (!i_resetn)
    reset_low_s ##0 i_op_kind == OP_PROGRAM && i_supply_ok
    |=> rec_ff == CNT_W'(PROGRAM_CYC))
    else $error("program recovery length wrong");

  // R8: sector recovery length
  rec_sector_a: assert property (@(posedge i_clk) // R8
    disable iff (!i_resetn)
    reset_low_s ##0 i_op_kind == OP_SECTOR_ERASE && i_supply_ok
    |=> rec_ff == CNT_W'(SECTOR_CYC))
    else $error("sector erase recovery length wrong");

  // R8: block recovery length
  rec_block_a: assert property (@(posedge i_clk) // R8
    disable iff (!i_resetn)
    reset_low_s ##0 i_op_kind == OP_BLOCK_ERASE && i_supply_ok
    |=> rec_ff == CNT_W'(BLOCK_CYC))
    else $error("block erase recovery length wrong");

  // R8: full array recovery
  rec_chip_a: assert property (@(posedge i_clk) // R8
    disable iff (!i_resetn)
    reset_low_s ##0 i_op_kind == OP_CHIP_ERASE && i_supply_ok
    |=> rec_ff == CNT_W'(CHIP_CYC))
    else $error("full erase recovery length wrong");

  // R9: register write recovery
  rec_regwr_a: assert property (@(posedge i_clk) // R9
    disable iff (!i_resetn)
    reset_low_s ##0 i_op_kind == OP_REG_WRITE && i_supply_ok
    |=> rec_ff == CNT_W'(REG_WRITE_CYC))
    else $error("register write recovery length wrong");

  // R6: recovery not shortened
  rec_hold_a: assert property (@(posedge i_clk) // R6
    disable iff (!i_resetn)
    state_ff == ST_RECOVER && i_restart_n && i_supply_ok &&
    cnt_ff + CNT_W'(1) < rec_ff |=> !o_ready)
    else $error("recovery ended early");

  // R3: abort lasts one cycle
  abort_once_a: assert property (@(posedge i_clk) // R3
    disable iff (!i_resetn)
    o_op_abort |=> !o_op_abort)
    else $error("abort pulse longer than one cycle");

  // R3: erase and register write work aborted
  abort_erase_a: assert property (@(posedge i_clk) // R3
    disable iff (!i_resetn)
    reset_low_s ##0 (i_op_kind == OP_SECTOR_ERASE ||
    i_op_kind == OP_BLOCK_ERASE || i_op_kind == OP_CHIP_ERASE ||
    i_op_kind == OP_REG_WRITE) |=> o_op_abort)
    else $error("erase or register write not aborted");

  // R3: read, decode and idle never aborted
  no_abort_rd_a: assert property (@(posedge i_clk) // R3
    disable iff (!i_resetn)
    reset_low_s ##0 (i_op_kind == OP_READ || i_op_kind == OP_DECODE ||
    i_op_kind == OP_IDLE) |=> !o_op_abort)
    else $error("abort raised for read work");

  // R4: output released after reset
  so_release_a: assert property (@(posedge i_clk) // R4
    disable iff (!i_resetn)
    o_core_reset |=> !o_so_oe)
    else $error("data output driven after reset cycle");

  // R10: power-up recovery start
  power_up_a: assert property (@(posedge i_clk) // R10
    disable iff (!i_resetn)
    state_ff == ST_POWER_HOLD && i_supply_ok |=>
    state_ff == ST_RECOVER && rec_ff == CNT_W'(PWR_REC_CYC))
    else $error("power-up recovery not started");

  // R11: commands ignored at low supply
  low_select_a: assert property (@(posedge i_clk) // R11
    disable iff (!i_resetn)
    !i_supply_ok |=> o_cs_n_core && !o_ready)
    else $error("select passed with low supply");

  // R2: standby with 3-byte address
  ready_mode_a: assert property (@(posedge i_clk) // R2
    disable iff (!i_resetn)
    $rose(o_ready) |-> !o_addr_4byte && !o_busy)
    else $error("wrong mode after reset");
endmodule

// ### test/host_model.sv
// Host model driving the reset pin and the chip select.
`timescale 1ns/1ps
module host_model #(parameter int SEL_CYC = 3) (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_act,
  input wire logic [7:0] i_len,
  output logic o_restart_n,
  output logic o_cs_n,
  output logic o_done
);
  int low = 0;
  int sel = 0;
  initial begin
    o_restart_n = 1'b1;
    o_cs_n = 1'b1;
    o_done = 1'b0;
  end
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_go) begin
      // pulse width set by the caller, select held high.
      o_restart_n <= 1'b0;
      o_cs_n <= 1'b1;
      low <= int'(i_len);
    end else if (low > 0) begin
      low <= low - 1;
      if (low == 1) begin
        o_restart_n <= 1'b1;
        sel <= SEL_CYC;
      end
    end else if (sel > 0) begin
      sel <= sel - 1;
      o_done <= (sel == 1);
    end else if (i_act) begin
      o_cs_n <= ~o_cs_n;
    end
  end
endmodule

// ### test/flash_reset_ctrl_tb.sv
// Testbench comparing the reset sequencer with a recovery table.
`timescale 1ns/1ps
module flash_reset_ctrl_tb;
  import flash_reset_pkg::*;
  localparam int LOW = 4;
  localparam int PWR = 8;
  localparam int REC[8] = '{9, 10, 9, 12, 14, 16, 20, 18};
  logic clk = 0, resetn = 0, supply_ok = 0, go = 0, act = 0;
  logic so_data = 0, so_oe = 1, restart_n, cs_n, done;
  logic so_d, so_e, core_rst, abort, ready, busy, cs_core, wel_clr, a4, dpd;
  logic [7:0] len = 8'h00;
  logic pd = 1'b0, pe = 1'b0, pr = 1'b0;
  op_kind_t op = OP_IDLE;
  int bad_count = 0, checked = 0, seed = 3, t, err, ab;
  always #5 clk = ~clk;
  host_model i_host_model (.i_clk(clk), .i_go(go), .i_act(act),
    .i_len(len), .o_restart_n(restart_n), .o_cs_n(cs_n), .o_done(done));
  flash_reset_ctrl #(.LOW_PULSE_CYC(LOW), .PWR_REC_CYC(PWR),
    .DECODE_CYC(REC[1]), .READ_CYC(REC[2]), .PROGRAM_CYC(REC[3]),
    .SECTOR_CYC(REC[4]), .BLOCK_CYC(REC[5]), .CHIP_CYC(REC[6]),
    .REG_WRITE_CYC(REC[7])) i_flash_reset_ctrl (.i_clk(clk),
    .i_resetn(resetn), .i_restart_n(restart_n), .i_supply_ok(supply_ok),
    .i_cs_n(cs_n), .i_op_kind(op), .i_so_data(so_data), .i_so_oe(so_oe),
    .o_so_data(so_d), .o_so_oe(so_e), .o_core_reset(core_rst),
    .o_op_abort(abort), .o_ready(ready), .o_busy(busy),
    .o_cs_n_core(cs_core), .o_write_enable_latch_clr(wel_clr),
    .o_addr_4byte(a4), .o_deep_power_down(dpd));
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wait_ready(input int lim);
    for (t = 0; t < lim; t++) begin
      @(posedge clk);
      #1;
      if (t > 0 && so_e !== (pe & pr & restart_n)) err = 1;
      if (t > 0 && so_d !== ((pe & pr) ? pd : 1'b0)) err = 1;
      pd = so_data;
      pe = so_oe;
      pr = ready;
      so_data <= 1'($random(seed));
      so_oe <= 1'($random(seed));
      if (abort === 1'b1) ab = 1;
      if (restart_n === 1'b0 && so_e !== 1'b0) err = 1;
      if (ready !== 1'b1 && (busy !== 1'b0 || cs_core !== 1'b1)) err = 1;
      if (ready === 1'b1 && t > 0) return;
    end
    bad_count++;
    report_and_stop();
  endtask
  task automatic pulse(input op_kind_t k, input int n);
    op <= k;
    len <= 8'(n);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    err = 0;
    ab = 0;
    wait_ready(400);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (20) @(posedge clk);
    chk("hold", 1'b1, core_rst);
    supply_ok <= 1'b1;
    err = 0;
    wait_ready(200);
    chk("power", 1'b1, t >= PWR && t <= PWR + 4);
    chk("dpd", 1'b0, dpd);
    chk("wel", 1'b0, wel_clr);
    chk("pwr_quiet", 0, err);
    $display("power-up test done");
    act <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      int n;
      n = LOW + ($random(seed) & 3);
      pulse(op_kind_t'(k), n);
      chk("abort", k >= int'(OP_PROGRAM), ab);
      chk("len", 1'b1, t >= n + REC[k] && t <= n + REC[k] + 4);
      chk("quiet", 0, err);
      chk("addr", 1'b0, a4);
    end
    $display("recovery test done");
    pulse(OP_READ, LOW - 1);
    chk("short", 1'b1, t <= LOW + 3);
    $display("short pulse test done");
    report_and_stop();
  end
endmodule
